/* File: pkg/qdf_cfg.svh */
// constants for the quad driver fault readout: bit layout, reset values, timing
`ifndef QDF_CFG_SVH
`define QDF_CFG_SVH

// ============================================================
// fault word layout
`define QDF_NCH          4
`define QDF_BITS_PER_CH  4
`define QDF_WORD_W       16
// position inside a channel nibble; the nibble's msb leaves first
`define QDF_OT_POS       3
`define QDF_SB_POS       2
`define QDF_SG_POS       1
`define QDF_OL_POS       0

// ============================================================
// reset values
`define QDF_FAULT_RST    16'h0000
`define QDF_SYNC_RST     23'h000004

// ============================================================
// timing
`define QDF_MCLK_MHZ     50
`define QDF_FILT_US      12
`define QDF_FILT_CYC     (`QDF_FILT_US * `QDF_MCLK_MHZ)
`define QDF_HALF_CYC     2
`define QDF_SETUP_CYC    10

`endif

/* File: pkg/qdf_if.sv */
// serial diagnostic link between the driver and its reading master
interface qdf_if;
  logic cs_n;
  logic sclk;
  logic sdo_out;
  logic sdo_oe;
  logic cascade_in;
  logic sdo;

  // released line reads low (weak pull-down on the board)
  assign sdo = sdo_oe & sdo_out;

  modport dev (
    input  cs_n,
    input  sclk,
    input  cascade_in,
    output sdo_out,
    output sdo_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output cascade_in,
    input  sdo
  );
endinterface : qdf_if

/* File: pkg/qdf_pkg.sv */
// types shared by both ends of the quad driver fault readout
package qdf_pkg;

  typedef logic [15:0] qdf_word_t;

  typedef enum logic [2:0] {
    QDF_IDLE,
    QDF_SETUP,
    QDF_HIGH,
    QDF_LOW,
    QDF_HOLD
  } qdf_host_state_e;

endpackage : qdf_pkg

/* File: rtl/qdf_device.sv */
// driver side: per-channel fault detection, fault register and serial readout
`include "qdf_cfg.svh"

// Summary of operation
// - chip select fall loads sixteen fault bits
// - four fault bits kept per channel
// - channel 1 first, OT SB SG OL
// - overtemp gates output, auto re-enable when cool
// - filtered overcurrent shuts output, sets bit
// - supply short latches off until input toggles
// - only supply short latches the drive
// - output off, low sense sets ground bit
// - output off, mid sense sets open bit
// - data is mode CPOL 0 CPHA 1
// - flag shown only until first clock edge
// - master may skip data when flag low
// - flag low means all data zero
// - flag high means master reads everything
// - upstream flag passes through to output
// - flag-capable device sits nearest master
// - cascade data follows own bits
// - first clock rise clears fault register
// - clock high at select blocks cascade
// - flag is OR, latched at select fall
// - first device cascade input tied low
module qdf_device #(
  parameter int FILT_CYC = `QDF_FILT_CYC
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  qdf_if.dev              link,
  input  wire logic [3:0] ch_in,
  input  wire logic [3:0] ot_sense,
  input  wire logic [3:0] oc_cmp,
  input  wire logic [3:0] gs_cmp,
  input  wire logic [3:0] ol_cmp,
  output logic      [3:0] drive_out,
  output qdf_pkg::qdf_word_t fault_word
);
  import qdf_pkg::*;

  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] FILT_TOP = CW'(FILT_CYC);

  // ============================================================
  // filter step: counts while the comparator stays high
  function automatic logic [CW-1:0] filt_next(input logic [CW-1:0] cnt,
                                             input logic lvl);
    if (!lvl)
      return '0;
    else if (cnt == FILT_TOP)
      return cnt;
    else
      return cnt + CW'(1);
  endfunction : filt_next

  // ============================================================
  // pin synchronisers (oscillator domain)
  logic [22:0] meta_ff;
  logic [22:0] sync_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_ff <= `QDF_SYNC_RST;
      sync_ff <= `QDF_SYNC_RST;
    end else if (ce) begin
      meta_ff <= {ch_in, ot_sense, oc_cmp, gs_cmp, ol_cmp,
                  link.cs_n, link.sclk, link.cascade_in};
      sync_ff <= meta_ff;
    end
  end

  wire [3:0] in_s    = sync_ff[22:19];
  wire [3:0] ot_s    = sync_ff[18:15];
  wire [3:0] oc_s    = sync_ff[14:11];
  wire [3:0] gs_s    = sync_ff[10:7];
  wire [3:0] ol_s    = sync_ff[6:3];
  wire       cs_n_s  = sync_ff[2];
  wire       sclk_s  = sync_ff[1];
  wire       casc_s  = sync_ff[0];

  // ============================================================
  // link domain: shift register on the master's clock
  logic      started_ff;
  qdf_word_t sh_ff;
  qdf_word_t snap_ff;
  logic      pre_do_ff;
  logic      oe_ff;

  // chip select clears the link side without a clock edge, since the
  // master's clock stands still between frames
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      started_ff <= 1'b0;
      sh_ff      <= `QDF_FAULT_RST;
    end else begin
      started_ff <= 1'b1;
      if (started_ff)
        sh_ff <= {sh_ff[14:0], link.cascade_in};
      else
        sh_ff <= snap_ff;
    end
  end

  // flag until the first rise, then the serial word's msb
  assign link.sdo_out = started_ff ? sh_ff[15] : pre_do_ff;
  assign link.sdo_oe  = oe_ff;

  // ============================================================
  // link-to-oscillator crossing of the frame start
  logic st_meta_ff;
  logic st_sync_ff;
  logic st_prev_ff;
  logic cs_prev_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_meta_ff <= 1'b0;
      st_sync_ff <= 1'b0;
      st_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
    end else if (ce) begin
      st_meta_ff <= started_ff;
      st_sync_ff <= st_meta_ff;
      st_prev_ff <= st_sync_ff;
      cs_prev_ff <= cs_n_s;
    end
  end

  wire cs_fall  = cs_prev_ff & ~cs_n_s;
  wire st_rise  = st_sync_ff & ~st_prev_ff;

  // ============================================================
  // per-channel protection and fault detection
  logic [3:0]  drive_ff;
  logic [3:0]  latch_off_ff;
  logic [3:0]  saw_off_ff;
  logic [15:0] fault_ev;

  genvar c;
  generate
    for (c = 0; c < `QDF_NCH; c = c + 1) begin : g_ch
      localparam int BASE = `QDF_WORD_W - `QDF_BITS_PER_CH * (c + 1);
      logic [CW-1:0] oc_cnt_ff;
      logic [CW-1:0] gs_cnt_ff;
      logic [CW-1:0] ol_cnt_ff;

      wire oc_filt = (oc_cnt_ff == FILT_TOP);
      wire gs_filt = (gs_cnt_ff == FILT_TOP);
      wire ol_filt = (ol_cnt_ff == FILT_TOP);
      // release needs the short gone plus an input off-then-on
      wire release_ok = saw_off_ff[c] & in_s[c] & ~oc_filt;
      // overtemp gates the drive directly, no latch
      wire nxt_drive = in_s[c] & ~ot_s[c] & ~latch_off_ff[c];

      always_ff @(posedge mclk) begin
        if (srst) begin
          oc_cnt_ff       <= '0;
          gs_cnt_ff       <= '0;
          ol_cnt_ff       <= '0;
          latch_off_ff[c] <= 1'b0;
          saw_off_ff[c]   <= 1'b0;
          drive_ff[c]     <= 1'b0;
        end else if (ce) begin
          oc_cnt_ff   <= filt_next(oc_cnt_ff, oc_s[c]);
          // off-state sensing is only meaningful with the switch open
          gs_cnt_ff   <= filt_next(gs_cnt_ff, gs_s[c] & ~drive_ff[c]);
          ol_cnt_ff   <= filt_next(ol_cnt_ff, ol_s[c] & ~drive_ff[c]);
          drive_ff[c] <= nxt_drive & ~oc_filt;
          if (oc_filt) begin
            latch_off_ff[c] <= 1'b1;
            saw_off_ff[c]   <= 1'b0;
          end else if (release_ok) begin
            latch_off_ff[c] <= 1'b0;
            saw_off_ff[c]   <= 1'b0;
          end else if (latch_off_ff[c] && !in_s[c]) begin
            saw_off_ff[c]   <= 1'b1;
          end
        end
      end

      assign fault_ev[BASE + `QDF_OT_POS] = ot_s[c];
      assign fault_ev[BASE + `QDF_SB_POS] = oc_filt;
      assign fault_ev[BASE + `QDF_SG_POS] = gs_filt & ~drive_ff[c];
      assign fault_ev[BASE + `QDF_OL_POS] = ol_filt & ~drive_ff[c];
    end
  endgenerate

  // ============================================================
  // parallel fault register, snapshot and flag
  qdf_word_t faults_ff;
  logic      flag_ff;
  logic      gate_ff;

  always_ff @(posedge mclk) begin
    if (srst) begin
      faults_ff <= `QDF_FAULT_RST;
      snap_ff   <= `QDF_FAULT_RST;
      flag_ff   <= 1'b0;
      gate_ff   <= 1'b0;
      pre_do_ff <= 1'b0;
      oe_ff     <= 1'b0;
    end else if (ce) begin
      // a new event in the clearing cycle survives the clear
      faults_ff <= (st_rise ? `QDF_FAULT_RST : faults_ff) | fault_ev;
      if (cs_fall) begin
        // flag and snapshot taken together so a low flag means zero data
        snap_ff <= faults_ff;
        flag_ff <= |faults_ff;
        gate_ff <= ~sclk_s;
      end else if (st_rise) begin
        gate_ff <= 1'b0;
      end
      pre_do_ff <= flag_ff | (gate_ff & casc_s);
      oe_ff     <= ~cs_n_s;
    end
  end

  // ============================================================
  // status outputs
  assign drive_out  = drive_ff;
  assign fault_word = faults_ff;

endmodule : qdf_device

/* File: rtl/qdf_host.sv */
// master side: reads the fault flag and, when asked, clocks out the chain
`include "qdf_cfg.svh"

module qdf_host #(
  parameter int NDEV  = 1,
  parameter int HALF  = `QDF_HALF_CYC,
  parameter int SETUP = `QDF_SETUP_CYC
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              ce,
  qdf_if.host                    link,
  input  wire logic              start,
  input  wire logic              skip_if_clean,
  output logic                   busy,
  output logic                   done,
  output logic                   flag,
  output logic [16*NDEV-1:0]     data
);
  import qdf_pkg::*;

  localparam int NBITS = 16 * NDEV;
  localparam int BW    = $clog2(NBITS + 1);
  localparam logic [7:0]    HALF_L  = 8'(HALF - 1);
  localparam logic [7:0]    SETUP_L = 8'(SETUP - 1);
  localparam logic [BW-1:0] LAST    = BW'(NBITS - 1);

  // ============================================================
  // data pin synchroniser
  logic sdo_meta_ff;
  logic sdo_sync_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      sdo_meta_ff <= 1'b0;
      sdo_sync_ff <= 1'b0;
    end else if (ce) begin
      sdo_meta_ff <= link.sdo;
      sdo_sync_ff <= sdo_meta_ff;
    end
  end

  // ============================================================
  // frame sequencer; the link clock is divided down from mclk
  qdf_host_state_e st_ff;
  logic [7:0]      tmr_ff;
  logic [BW-1:0]   bit_ff;
  logic            cs_n_ff;
  logic            sclk_ff;

  wire tmr_half  = (tmr_ff == HALF_L);
  wire tmr_setup = (tmr_ff == SETUP_L);

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff   <= QDF_IDLE;
      tmr_ff  <= '0;
      bit_ff  <= '0;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      busy    <= 1'b0;
      done    <= 1'b0;
      flag    <= 1'b0;
      data    <= '0;
    end else if (ce) begin
      done   <= 1'b0;
      tmr_ff <= tmr_ff + 8'h01;
      unique case (st_ff)
        QDF_IDLE: begin
          if (start) begin
            cs_n_ff <= 1'b0;
            sclk_ff <= 1'b0;
            busy    <= 1'b1;
            bit_ff  <= '0;
            tmr_ff  <= '0;
            st_ff   <= QDF_SETUP;
          end
        end
        QDF_SETUP: begin
          if (tmr_setup) begin
            flag   <= sdo_sync_ff;
            tmr_ff <= '0;
            if (!sdo_sync_ff && skip_if_clean) begin
              data  <= '0;
              st_ff <= QDF_HOLD;
            end else begin
              sclk_ff <= 1'b1;
              st_ff   <= QDF_HIGH;
            end
          end
        end
        QDF_HIGH: begin
          if (tmr_half) begin
            sclk_ff <= 1'b0;
            tmr_ff  <= '0;
            st_ff   <= QDF_LOW;
          end
        end
        QDF_LOW: begin
          if (tmr_half) begin
            // sample late in the low phase, after the second edge
            data   <= {data[NBITS-2:0], sdo_sync_ff};
            bit_ff <= bit_ff + BW'(1);
            tmr_ff <= '0;
            if (bit_ff == LAST) begin
              st_ff <= QDF_HOLD;
            end else begin
              sclk_ff <= 1'b1;
              st_ff   <= QDF_HIGH;
            end
          end
        end
        QDF_HOLD: begin
          if (tmr_half) begin
            cs_n_ff <= 1'b1;
            busy    <= 1'b0;
            done    <= 1'b1;
            st_ff   <= QDF_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cs_n       = cs_n_ff;
  assign link.sclk       = sclk_ff;
  // this master reads a single flag-capable device at the chain end
  assign link.cascade_in = 1'b0;
endmodule : qdf_host

/* File: test/qdf_checker.sv */
// link checker: frame properties sampled on the oscillator clock
module qdf_checker #(
  parameter int NDEV = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic cascade_in,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;

  // ====================
  // frame tracking
  logic       sclk_q_ff;
  logic       sdo_q_ff;
  logic       started_ff;
  logic       flag_ff;
  logic [7:0] rises_ff;
  wire logic  sclk_rise;
  wire logic  clean;

  assign sclk_rise = sclk & ~sclk_q_ff;
  // the flag is what the line showed one sample before the first rise
  assign clean = (started_ff & ~flag_ff) | (~started_ff & sclk_rise & ~sdo_q_ff);

  always_ff @(posedge mclk) begin
    sclk_q_ff <= sclk;
    sdo_q_ff  <= sdo;
    if (sclk_rise && !started_ff) begin
      flag_ff <= sdo_q_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || cs_n) begin
      started_ff <= 1'b0;
      rises_ff   <= 8'h00;
    end else if (sclk_rise) begin
      started_ff <= 1'b1;
      rises_ff   <= rises_ff + 8'h01;
    end
  end

  // ====================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_release; cs_n [*5] |-> !sdo_oe; endproperty
  a_release: assert property (p_release) else $error("output not released");
  property p_oe_up; $fell(cs_n) |-> ##[2:6] sdo_oe; endproperty
  a_oe_up: assert property (p_oe_up) else $error("output not driven");
  property p_idle_low; cs_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock not idle low");
  property p_sel_low; $fell(cs_n) |-> !sclk && !$past(sclk); endproperty
  a_sel_low: assert property (p_sel_low) else $error("clock high at select");
  property p_flag_stand; $fell(cs_n) |-> ##7 $stable(sdo_out) [*3]; endproperty
  a_flag_stand: assert property (p_flag_stand) else $error("flag moved");
  property p_data_hold; !cs_n && !sclk && $past(sclk) |-> $stable(sdo_out); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved on fall");
  property p_clean_zero; !cs_n && clean |-> !sdo; endproperty
  a_clean_zero: assert property (p_clean_zero) else $error("data set, flag low");
  property p_bit_count;
    $rose(cs_n) |-> (rises_ff == 8'h00) || (rises_ff == 8'(16 * NDEV));
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("bad clock count");
  property p_cascade_tied; !cascade_in; endproperty
  a_cascade_tied: assert property (p_cascade_tied) else $error("cascade not low");
endmodule : qdf_checker

/* File: test/tb_quad_driver_fault_readout.sv */
// bench: master and driver joined over the serial link
module tb_quad_driver_fault_readout;
  timeunit 1ns;
  timeprecision 100ps;
  import qdf_pkg::*;

  // ====================
  // signals and instances
  logic        mclk;
  logic        srst;
  logic        start;
  logic        skip;
  logic [3:0]  ch_in, ot, oc, gs, ol, drive;
  qdf_word_t   fw, data, w;
  logic        busy, done, flag;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  int          num_errors, cmp_count;
  int          cyc = 0;

  qdf_if i_qdf_if ();
  qdf_device #(.FILT_CYC(4)) i_qdf_device (.mclk(mclk), .srst(srst), .ce(1'b1),
    .link(i_qdf_if), .ch_in(ch_in), .ot_sense(ot), .oc_cmp(oc), .gs_cmp(gs),
    .ol_cmp(ol), .drive_out(drive), .fault_word(fw));
  qdf_host #(.NDEV(1)) i_qdf_host (.mclk(mclk), .srst(srst), .ce(1'b1),
    .link(i_qdf_if), .start(start), .skip_if_clean(skip), .busy(busy), .done(done),
    .flag(flag), .data(data));
  qdf_checker #(.NDEV(1)) i_qdf_checker (.mclk(mclk), .srst(srst),
    .cs_n(i_qdf_if.cs_n), .sclk(i_qdf_if.sclk), .sdo_out(i_qdf_if.sdo_out),
    .sdo_oe(i_qdf_if.sdo_oe), .cascade_in(i_qdf_if.cascade_in), .sdo(i_qdf_if.sdo));

  // ====================
  // tasks
  task automatic chk(string nm, logic [16:0] ex, logic [16:0] got);
    cmp_count++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic frame(logic [15:0] ex, logic sk);
    exp_q.push_back({|ex, ex});
    skip  = sk;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (int n = 0; n < 200 && busy !== 1'b0; n++) tick(1);
    // a frame that never ends is a mismatch, not a silent skip
    if (busy !== 1'b0) begin
      num_errors++;
      $display("unexpected busy exp 0 got %b", busy);
    end
    // keep select high long enough before the next frame
    tick(8);
  endtask : frame

  // pattern is in parallel register order, channel 1 at the top
  task automatic apply(logic [15:0] p);
    for (int c = 0; c < 4; c++) begin
      ot[c] = p[15-4*c];
      oc[c] = p[14-4*c];
      gs[c] = p[13-4*c];
      ol[c] = p[12-4*c];
    end
    tick(12);
    {ot, oc, gs, ol} = 16'h0000;
    tick(6);
  endtask : apply

  task automatic results;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // ====================
  // clock, monitor, timeout, stimulus
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // outputs read on the falling edge, half a cycle after they settle
  always @(negedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      results;
    end else if (done === 1'b1) begin
      e = exp_q.pop_front();
      chk("frame", e, {flag, data});
    end
  end

  initial begin
    srst  = 1'b1;
    start = 1'b0;
    skip  = 1'b0;
    ch_in = 4'h0;
    {ot, oc, gs, ol} = 16'h0000;
    num_errors = 0;
    cmp_count  = 0;
    void'($urandom(12458));
    repeat (10) @(posedge mclk);
    #1;
    srst = 1'b0;
    tick(3);
    frame(16'h0000, 1'b1);
    // clean device clocked out in full: all sixteen data bits low
    frame(16'h0000, 1'b0);
    // every output off: all four detectors may report
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($urandom);
      apply(w);
      chk("fault_word", {1'b0, w}, {1'b0, fw});
      frame(w, 1'($urandom));
      chk("cleared", 17'h00000, {1'b0, fw});
    end
    ch_in = 4'hF;
    tick(8);
    chk("drive", 17'h0000F, {13'h0000, drive});
    ot = 4'h1;
    tick(4);
    chk("drive", 17'h0000E, {13'h0000, drive});
    ot = 4'h0;
    oc = 4'h2;
    gs = 4'h4;
    ol = 4'h8;
    tick(12);
    chk("drive", 17'h0000D, {13'h0000, drive});
    {oc, gs, ol} = 12'h000;
    tick(8);
    chk("drive", 17'h0000D, {13'h0000, drive});
    ch_in = 4'hD;
    tick(6);
    ch_in = 4'hF;
    tick(8);
    chk("drive", 17'h0000F, {13'h0000, drive});
    frame(16'h8400, 1'b1);
    chk("pending", 17'h00000, 17'(exp_q.size()));
    results;
  end
endmodule : tb_quad_driver_fault_readout
